// *** inc/lpf_regs.svh ***
`ifndef LPF_REGS_SVH
`define LPF_REGS_SVH

// =====================================================================
// channel and timer counts
`define LPF_NUM_TMR 8
`define LPF_NUM_HS_TMR 4
`define LPF_NUM_CHN 16
`define LPF_NUM_HS_CHN 8

// =====================================================================
// field widths and positions
`define LPF_DIV_W 18
`define LPF_DIV_INT_MSB 17
`define LPF_DIV_INT_LSB 8
`define LPF_DIV_FRAC_MSB 7
`define LPF_DIV_INT_W 10
`define LPF_CNT_W 20
`define LPF_RES_W 5
`define LPF_DUTY_W 25
`define LPF_DUTY_INT_MSB 24
`define LPF_DUTY_INT_LSB 4
`define LPF_DUTY_FRAC_MSB 3
`define LPF_FADE_W 10

// =====================================================================
// reset values
`define LPF_CNT_RST 20'h00000
`define LPF_DIV_CNT_RST 10'h000
`define LPF_FRAC_RST 8'h00

`endif

// *** inc/lpf_pkg.sv ***
`include "lpf_regs.svh"

package lpf_pkg;

    // =================================================================
    // configuration carriers
    typedef struct packed {
        logic [`LPF_DIV_W-1:0] divider_factor;
        logic [`LPF_RES_W-1:0] counter_resolution;
        logic clock_source_select;
        logic pause;
        logic counter_reset;
        logic low_speed_param_update;
    } lpf_tmr_cfg_s;

    typedef struct packed {
        logic [1:0] timer_select;
        logic [`LPF_CNT_W-1:0] channel_high_point;
        logic [`LPF_DUTY_W-1:0] duty;
        logic duty_load;
        logic fade_start;
        logic fade_increment;
        logic [`LPF_FADE_W-1:0] fade_cycle;
        logic [`LPF_FADE_W-1:0] fade_scale;
        logic [`LPF_FADE_W-1:0] fade_num;
    } lpf_chn_cfg_s;

    // =================================================================
    // state types
    typedef enum logic {
        FADE_IDLE = 1'b0,
        FADE_RUN = 1'b1
    } lpf_fade_e;

    typedef struct packed {
        logic [`LPF_CNT_W-1:0] cnt;
        logic [`LPF_DIV_INT_W-1:0] div_cnt;
        logic [`LPF_DIV_FRAC_MSB:0] frac_acc;
        logic [`LPF_DIV_W-1:0] act_div;
        logic [`LPF_RES_W-1:0] act_res;
    } lpf_tmr_st_s;

    typedef struct packed {
        lpf_fade_e fade;
        logic out;
        logic [`LPF_DUTY_W-1:0] duty;
        logic [`LPF_DUTY_FRAC_MSB:0] dither_acc;
        logic extend;
        logic [`LPF_FADE_W-1:0] cyc_cnt;
        logic [`LPF_FADE_W-1:0] step_cnt;
    } lpf_chn_st_s;

    typedef struct packed {
        lpf_tmr_st_s [`LPF_NUM_TMR-1:0] tmr;
        lpf_chn_st_s [`LPF_NUM_CHN-1:0] chn;
        logic [`LPF_NUM_TMR-1:0] ovf_irq;
        logic [`LPF_NUM_CHN-1:0] done_irq;
    } lpf_state_s;

endpackage

// *** hw/lpf_led_pwm.sv ***
`timescale 1ns/1ps
`include "lpf_regs.svh"

// Functional notes
// - Sixteen channels: eight high-speed, eight low-speed.
// - Each channel picks one of the four timers of its own group.
// - High-speed timer clocks from reference tick or the bus clock.
// - Divider is 18-bit fixed point: 10 integer bits, 8 fraction bits.
// - Fraction B gives B long periods of A+1 per 256, spread evenly.
// - Counter increments per divided clock, wraps to zero at 2^res-1, flags overflow.
// - Software can reset, pause and read each counter.
// - Each timer presents its 20-bit count; wrap period sets channel frequency.
// - Output frequency is source clock over divider times 2^resolution.
// - Low-speed timers use reference tick or slow clock; slow clock is bus or 8 MHz.
// - High-speed range and divider changes take effect at the next overflow.
// - Low-speed range and divider change only on the update bit or a counter reset.
// - Output goes high when count equals the high point.
// - Output goes low when count reaches high point plus integer duty.
// - Nonzero duty fraction lengthens pulses by one cycle at rate fraction/16.
// - Fade start steps duty automatically, up or down by direction bit.
// - After each step interval the step size is added to or subtracted from duty.
// - Fade stops after the programmed number of steps.
// - Finished fade raises a per-channel done interrupt, per speed group.
// - Each timer overflow raises its own interrupt, per speed group.
module lpf_led_pwm (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic ref_tick_in,
    input wire logic clk8m_tick_in,
    input wire logic slow_clk_apb_sel_in,
    input wire lpf_pkg::lpf_tmr_cfg_s [`LPF_NUM_TMR-1:0] tmr_cfg_in,
    input wire lpf_pkg::lpf_chn_cfg_s [`LPF_NUM_CHN-1:0] chn_cfg_in,
    output logic [`LPF_NUM_CHN-1:0] pwm_out,
    output logic [`LPF_NUM_TMR-1:0][`LPF_CNT_W-1:0] tmr_count_out,
    output logic [`LPF_NUM_CHN-1:0][`LPF_DUTY_W-1:0] duty_now_out,
    output logic [`LPF_NUM_HS_TMR-1:0] high_speed_timer_overflow_irq_out,
    output logic [`LPF_NUM_HS_TMR-1:0] low_speed_timer_overflow_irq_out,
    output logic [`LPF_NUM_HS_CHN-1:0] high_speed_fade_done_irq_out,
    output logic [`LPF_NUM_HS_CHN-1:0] low_speed_fade_done_irq_out
);

    // =================================================================
    // operating notes
    //
    // timers 0..3 are high-speed, 4..7
    // low-speed; channels 8..15 use the
    // low-speed timers.
    //
    // source ticks are enables on the
    // module clock: the bus clock ticks
    // every cycle, the others only when
    // their tick input is high.
    //
    // the fraction accumulator picks
    // which divided periods get an extra
    // tick, so long periods never bunch.
    //
    // the counter runs on shadow copies
    // of divider and range; they load at
    // an overflow (high-speed) or on the
    // update bit (low-speed), so a change
    // in mid-period leaves no runt pulse.
    //
    // counter reset also loads the
    // shadows, so a restart never runs
    // on stale settings.
    //
    // the output is a flip-flop, so the
    // whole waveform lags the compares by
    // one clock; the duty is unchanged.
    //
    // fades do not saturate: a step past
    // zero or the top of the range wraps,
    // so keep step size times step count
    // inside the duty range.
    //
    // dither is a four-bit accumulator
    // stepped once per timer period: a
    // fraction of f sixteenths lengthens
    // exactly f pulses in sixteen, with
    // no random source to seed.
    //
    // a fade steps once per fade_cycle timer periods;
    // zero cycle or step counts act as one.
    //
    // interrupt outputs are one-cycle
    // pulses; latching lives outside.

    // =================================================================
    // helpers
    function automatic logic [`LPF_CNT_W-1:0] res_max(input logic [`LPF_RES_W-1:0] r);
        logic [`LPF_CNT_W:0] m;
        // resolutions above 20 saturate to the full counter width
        m = (21'h000001 << r) - 21'h000001;
        return m[`LPF_CNT_W-1:0];
    endfunction

    function automatic logic [20:0] step_duty(input logic [20:0] d, input logic [`LPF_FADE_W-1:0] s,
                                              input logic inc);
        // no clamping: software must keep the fade inside the counter range
        return inc ? d + {11'h000, s} : d - {11'h000, s};
    endfunction

    // =================================================================
    // state
    lpf_pkg::lpf_state_s st_reg;
    lpf_pkg::lpf_state_s st_next;

    // per-timer working signals
    logic slow_tick;
    logic [`LPF_NUM_TMR-1:0] src_tick;
    logic [`LPF_NUM_TMR-1:0] t_tick;
    logic [`LPF_NUM_TMR-1:0] t_ovf;
    logic [`LPF_NUM_TMR-1:0][8:0] frac_sum;
    logic [`LPF_NUM_TMR-1:0][`LPF_DIV_INT_W:0] period;

    // per-channel working signals
    logic [`LPF_NUM_CHN-1:0][2:0] chn_tmr;
    logic [`LPF_NUM_CHN-1:0][`LPF_CNT_W-1:0] chn_cnt;
    logic [`LPF_NUM_CHN-1:0][`LPF_CNT_W-1:0] low_pt;
    logic [`LPF_NUM_CHN-1:0][4:0] dither_sum;
    logic [`LPF_NUM_CHN-1:0][20:0] high_sum;

    // =================================================================
    // next-state logic: timers first, channels read their ticks
    always_comb begin
        st_next = st_reg;
        st_next.ovf_irq = '0;
        st_next.done_irq = '0;

        // the bus clock is the module clock, so selecting it means a tick every cycle
        slow_tick = slow_clk_apb_sel_in | clk8m_tick_in;
        for (int t = 0; t < `LPF_NUM_TMR; t++) begin
            if (tmr_cfg_in[t].clock_source_select) begin
                src_tick[t] = (t < `LPF_NUM_HS_TMR) ? 1'b1 : slow_tick;
            end else begin
                src_tick[t] = ref_tick_in;
            end

            // carry out of the fraction accumulator lengthens one period by a cycle
            frac_sum[t] = {1'b0, st_reg.tmr[t].frac_acc}
                        + {1'b0, st_reg.tmr[t].act_div[`LPF_DIV_FRAC_MSB:0]};
            period[t] = {1'b0, st_reg.tmr[t].act_div[`LPF_DIV_INT_MSB:`LPF_DIV_INT_LSB]}
                      + {10'h000, frac_sum[t][8]};

            t_tick[t] = 1'b0;
            t_ovf[t] = 1'b0;
            if (tmr_cfg_in[t].counter_reset) begin
                st_next.tmr[t].cnt = `LPF_CNT_RST;
                st_next.tmr[t].div_cnt = `LPF_DIV_CNT_RST;
                st_next.tmr[t].frac_acc = `LPF_FRAC_RST;
            end else if (!tmr_cfg_in[t].pause && src_tick[t]) begin
                // a zero period divides by one
                if ({1'b0, st_reg.tmr[t].div_cnt} + 11'h001 >= period[t]) begin
                    st_next.tmr[t].div_cnt = `LPF_DIV_CNT_RST;
                    st_next.tmr[t].frac_acc = frac_sum[t][7:0];
                    t_tick[t] = 1'b1;
                end else begin
                    st_next.tmr[t].div_cnt = st_reg.tmr[t].div_cnt + 10'h001;
                end
            end

            if (t_tick[t]) begin
                if (st_reg.tmr[t].cnt == res_max(st_reg.tmr[t].act_res)) begin
                    st_next.tmr[t].cnt = `LPF_CNT_RST;
                    t_ovf[t] = 1'b1;
                end else begin
                    st_next.tmr[t].cnt = st_reg.tmr[t].cnt + 20'h00001;
                end
            end

            // high-speed shadows load at overflow, low-speed on the update bit
            if (tmr_cfg_in[t].counter_reset
                || ((t < `LPF_NUM_HS_TMR) ? t_ovf[t] : tmr_cfg_in[t].low_speed_param_update)) begin
                st_next.tmr[t].act_div = tmr_cfg_in[t].divider_factor;
                st_next.tmr[t].act_res = tmr_cfg_in[t].counter_resolution;
            end

            st_next.ovf_irq[t] = t_ovf[t];
        end

        for (int c = 0; c < `LPF_NUM_CHN; c++) begin
            chn_tmr[c] = {(c >= `LPF_NUM_HS_CHN) ? 1'b1 : 1'b0, chn_cfg_in[c].timer_select};
            chn_cnt[c] = st_reg.tmr[chn_tmr[c]].cnt;
            high_sum[c] = {1'b0, chn_cfg_in[c].channel_high_point}
                        + st_reg.chn[c].duty[`LPF_DUTY_INT_MSB:`LPF_DUTY_INT_LSB]
                        + {20'h00000, st_reg.chn[c].extend};
            low_pt[c] = high_sum[c][`LPF_CNT_W-1:0];

            dither_sum[c] = {1'b0, st_reg.chn[c].dither_acc} + {1'b0, st_reg.chn[c].duty[`LPF_DUTY_FRAC_MSB:0]};

            // high point wins when both compare values coincide
            if (chn_cnt[c] == chn_cfg_in[c].channel_high_point) begin
                st_next.chn[c].out = 1'b1;
            end else if (chn_cnt[c] == low_pt[c]) begin
                st_next.chn[c].out = 1'b0;
            end

            // one dither decision per pwm period keeps the long pulses evenly spread
            if (t_ovf[chn_tmr[c]]) begin
                st_next.chn[c].dither_acc = dither_sum[c][3:0];
                st_next.chn[c].extend = dither_sum[c][4];
            end

            if (chn_cfg_in[c].duty_load) begin
                st_next.chn[c].duty = chn_cfg_in[c].duty;
                st_next.chn[c].fade = lpf_pkg::FADE_IDLE;
            end

            if (chn_cfg_in[c].fade_start) begin
                st_next.chn[c].fade = lpf_pkg::FADE_RUN;
                st_next.chn[c].cyc_cnt = '0;
                st_next.chn[c].step_cnt = '0;
            end else if (!chn_cfg_in[c].duty_load && st_reg.chn[c].fade == lpf_pkg::FADE_RUN
                         && t_ovf[chn_tmr[c]]) begin
                if ({1'b0, st_reg.chn[c].cyc_cnt} + 11'h001 >= {1'b0, chn_cfg_in[c].fade_cycle}) begin
                    st_next.chn[c].cyc_cnt = '0;
                    st_next.chn[c].duty[`LPF_DUTY_INT_MSB:`LPF_DUTY_INT_LSB] =
                        step_duty(st_reg.chn[c].duty[`LPF_DUTY_INT_MSB:`LPF_DUTY_INT_LSB],
                                  chn_cfg_in[c].fade_scale, chn_cfg_in[c].fade_increment);
                    st_next.chn[c].step_cnt = st_reg.chn[c].step_cnt + 10'h001;
                    if ({1'b0, st_reg.chn[c].step_cnt} + 11'h001 >= {1'b0, chn_cfg_in[c].fade_num}) begin
                        st_next.chn[c].fade = lpf_pkg::FADE_IDLE;
                        st_next.done_irq[c] = 1'b1;
                    end
                end else begin
                    st_next.chn[c].cyc_cnt = st_reg.chn[c].cyc_cnt + 10'h001;
                end
            end
        end
    end

    // =================================================================
    // state register; zero state means idle fades and low outputs
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // =================================================================
    // outputs straight from the state register
    always_comb begin
        for (int c = 0; c < `LPF_NUM_CHN; c++) begin
            pwm_out[c] = st_reg.chn[c].out;
            duty_now_out[c] = st_reg.chn[c].duty;
        end

        for (int t = 0; t < `LPF_NUM_TMR; t++) begin
            tmr_count_out[t] = st_reg.tmr[t].cnt;
        end

        high_speed_timer_overflow_irq_out = st_reg.ovf_irq[3:0];
        low_speed_timer_overflow_irq_out = st_reg.ovf_irq[7:4];
        high_speed_fade_done_irq_out = st_reg.done_irq[7:0];
        low_speed_fade_done_irq_out = st_reg.done_irq[15:8];
    end

    // =================================================================
    // timer checks
    for (genvar t = 0; t < `LPF_NUM_TMR; t++) begin : g_tmr_chk
        a_cnt_wrap_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
            t_ovf[t] |=> st_reg.tmr[t].cnt == 20'h00000 && st_reg.ovf_irq[t])
            else $error("counter did not wrap to zero with overflow flag");

        a_pause_holds_count: assert property (@(posedge clock_in) disable iff (!resetn_in)
            tmr_cfg_in[t].pause && !tmr_cfg_in[t].counter_reset |=> $stable(st_reg.tmr[t].cnt))
            else $error("paused counter moved");

        a_soft_reset_clears: assert property (@(posedge clock_in) disable iff (!resetn_in)
            tmr_cfg_in[t].counter_reset |=> st_reg.tmr[t].cnt == 20'h00000 && st_reg.tmr[t].div_cnt == 10'h000)
            else $error("software reset left counter nonzero");

        a_cnt_step_one: assert property (@(posedge clock_in) disable iff (!resetn_in)
            t_tick[t] && !t_ovf[t] |=> st_reg.tmr[t].cnt == $past(st_reg.tmr[t].cnt) + 20'h00001)
            else $error("counter did not step by one");

        a_no_tick_paused: assert property (@(posedge clock_in) disable iff (!resetn_in)
            tmr_cfg_in[t].pause |-> !t_tick[t])
            else $error("divided tick while paused");
        if (t < `LPF_NUM_HS_TMR) begin : g_hs
            a_hs_shadow_ovf: assert property (@(posedge clock_in) disable iff (!resetn_in)
                $changed(st_reg.tmr[t].act_div) || $changed(st_reg.tmr[t].act_res)
                |-> $past(t_ovf[t]) || $past(tmr_cfg_in[t].counter_reset))
                else $error("high-speed settings changed away from overflow");

            a_hs_clock_src: assert property (@(posedge clock_in) disable iff (!resetn_in)
                src_tick[t] == (tmr_cfg_in[t].clock_source_select || ref_tick_in))
                else $error("high-speed source tick mismatch");
        end else begin : g_ls
            a_ls_shadow_upd: assert property (@(posedge clock_in) disable iff (!resetn_in)
                $changed(st_reg.tmr[t].act_div) || $changed(st_reg.tmr[t].act_res)
                |-> $past(tmr_cfg_in[t].low_speed_param_update) || $past(tmr_cfg_in[t].counter_reset))
                else $error("low-speed settings changed without update bit");

            a_ls_clock_src: assert property (@(posedge clock_in) disable iff (!resetn_in)
                src_tick[t] == (tmr_cfg_in[t].clock_source_select ? slow_clk_apb_sel_in || clk8m_tick_in : ref_tick_in))
                else $error("low-speed source tick mismatch");
        end
    end

    // =================================================================
    // channel checks
    for (genvar c = 0; c < `LPF_NUM_CHN; c++) begin : g_chn_chk
        a_out_high_point: assert property (@(posedge clock_in) disable iff (!resetn_in)
            chn_cnt[c] == chn_cfg_in[c].channel_high_point |=> pwm_out[c])
            else $error("output not high at high point");

        a_out_low_point: assert property (@(posedge clock_in) disable iff (!resetn_in)
            chn_cnt[c] == low_pt[c] && chn_cnt[c] != chn_cfg_in[c].channel_high_point |=> !pwm_out[c])
            else $error("output not low at low point");

        a_fade_done_irq: assert property (@(posedge clock_in) disable iff (!resetn_in)
            st_reg.done_irq[c] |-> $past(st_reg.chn[c].fade) == lpf_pkg::FADE_RUN
                                   && st_reg.chn[c].fade == lpf_pkg::FADE_IDLE ##1 !st_reg.done_irq[c])
            else $error("fade done pulse without finishing fade");

        a_fade_step_dir: assert property (@(posedge clock_in) disable iff (!resetn_in)
            st_reg.chn[c].fade == lpf_pkg::FADE_RUN && !chn_cfg_in[c].fade_start && !chn_cfg_in[c].duty_load
            && chn_cfg_in[c].fade_increment && chn_cfg_in[c].fade_scale != 10'h000
            && st_next.chn[c].step_cnt != st_reg.chn[c].step_cnt
            |=> st_reg.chn[c].duty[24:4] == $past(st_reg.chn[c].duty[24:4]) + {11'h000, $past(chn_cfg_in[c].fade_scale)})
            else $error("fade step did not add step size");

        a_fade_step_down: assert property (@(posedge clock_in) disable iff (!resetn_in)
            st_reg.chn[c].fade == lpf_pkg::FADE_RUN && !chn_cfg_in[c].fade_start && !chn_cfg_in[c].duty_load
            && !chn_cfg_in[c].fade_increment && st_next.chn[c].step_cnt != st_reg.chn[c].step_cnt
            |=> st_reg.chn[c].duty[24:4] == $past(st_reg.chn[c].duty[24:4]) - {11'h000, $past(chn_cfg_in[c].fade_scale)})
            else $error("fade step did not subtract step size");

        a_fade_idle_duty: assert property (@(posedge clock_in) disable iff (!resetn_in)
            st_reg.chn[c].fade == lpf_pkg::FADE_IDLE && !chn_cfg_in[c].duty_load |=> $stable(st_reg.chn[c].duty))
            else $error("duty moved with no fade running");

        a_dither_none: assert property (@(posedge clock_in) disable iff (!resetn_in)
            st_reg.chn[c].duty[3:0] == 4'h0 && st_reg.chn[c].dither_acc == 4'h0 && !st_reg.chn[c].extend |=> !st_reg.chn[c].extend)
            else $error("pulse lengthened with zero fraction");

        a_duty_load_takes: assert property (@(posedge clock_in) disable iff (!resetn_in)
            chn_cfg_in[c].duty_load |=> st_reg.chn[c].duty == $past(chn_cfg_in[c].duty))
            else $error("loaded duty not taken");
    end

endmodule // lpf_led_pwm

// *** testbench/lpf_load_model.sv ***
`timescale 1ns/1ps
`include "lpf_regs.svh"

// =====================================================================
// load model: a bank of leds that integrate on-time per channel
module lpf_load_model (
    input wire logic clock_in,
    input wire logic clear_in,
    input wire logic [`LPF_NUM_CHN-1:0] pwm_in,
    output logic [`LPF_NUM_CHN-1:0][15:0] on_cycles_out
);
    // on-time per window stands in for brightness; phase is not seen
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < `LPF_NUM_CHN; i++) begin
            if (clear_in) begin
                on_cycles_out[i] <= 16'h0000;
            end else begin
                on_cycles_out[i] <= on_cycles_out[i] + 16'(pwm_in[i]);
            end
        end
    end
endmodule // lpf_load_model

// *** testbench/lpf_led_pwm_test.sv ***
`timescale 1ns/1ps
`include "lpf_regs.svh"

// =====================================================================
// bench top
module lpf_led_pwm_test;
    localparam int REF_GAP = 4; // reference tick spacing in clocks
    localparam int K8_GAP = 31; // whole-cycle stand-in for the 8 MHz tick
    typedef struct {int t; int a; int b; int res; int src; int slow;} lpf_row_s;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic ref_tick_in = 1'b0;
    logic clk8m_tick_in = 1'b0;
    logic slow_clk_apb_sel_in = 1'b0;
    logic clear = 1'b1;
    lpf_pkg::lpf_tmr_cfg_s [`LPF_NUM_TMR-1:0] tmr_cfg_in = '0;
    lpf_pkg::lpf_chn_cfg_s [`LPF_NUM_CHN-1:0] chn_cfg_in = '0;
    logic [`LPF_NUM_CHN-1:0] pwm_out;
    logic [`LPF_NUM_TMR-1:0][`LPF_CNT_W-1:0] tmr_count_out;
    logic [`LPF_NUM_CHN-1:0][`LPF_DUTY_W-1:0] duty_now_out;
    logic [3:0] hs_ovf;
    logic [3:0] ls_ovf;
    logic [7:0] hs_done;
    logic [7:0] ls_done;
    logic [`LPF_NUM_CHN-1:0][15:0] on_cycles;
    logic [23:0] ev;
    int err_count = 0;
    int check_count = 0;
    int tick_n = 0;
    int n;
    // timer, A, B, resolution, source, slow select
    lpf_row_s rows[7] = '{'{0, 1, 0, 2, 1, 0}, '{1, 3, 0, 3, 1, 0}, '{2, 2, 128, 8, 1, 0}, '{3, 1, 0, 2, 0, 0},
                          '{4, 1, 0, 2, 1, 1}, '{5, 2, 0, 1, 1, 0}, '{6, 1, 0, 1, 0, 0}};

    // event map: timers 0..7 then channels 8..23
    assign ev = {ls_done, hs_done, ls_ovf, hs_ovf};
    always #2 clock_in = ~clock_in;

    // source ticks change at the falling edge like every other input
    always @(negedge clock_in) begin
        tick_n <= tick_n + 1;
        ref_tick_in <= (tick_n % REF_GAP) == 0;
        clk8m_tick_in <= (tick_n % K8_GAP) == 0;
    end

    lpf_led_pwm lpf_led_pwm_i (.clock_in(clock_in), .resetn_in(resetn_in), .ref_tick_in(ref_tick_in),
        .clk8m_tick_in(clk8m_tick_in), .slow_clk_apb_sel_in(slow_clk_apb_sel_in), .tmr_cfg_in(tmr_cfg_in),
        .chn_cfg_in(chn_cfg_in), .pwm_out(pwm_out), .tmr_count_out(tmr_count_out), .duty_now_out(duty_now_out),
        .high_speed_timer_overflow_irq_out(hs_ovf), .low_speed_timer_overflow_irq_out(ls_ovf),
        .high_speed_fade_done_irq_out(hs_done), .low_speed_fade_done_irq_out(ls_done));
    lpf_load_model lpf_load_model_i (.clock_in(clock_in), .clear_in(clear), .pwm_in(pwm_out),
        .on_cycles_out(on_cycles));

    // =====================================================================
    // helpers
    task automatic stop_test();
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_int(input string what, input int exp, input int seen);
        check_count++;
        if (exp != seen) begin
            err_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic chk_vec(input string what, input logic [24:0] exp, input logic [24:0] seen);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // counts falling edges up to the next event pulse, bounded
    task automatic wait_ev(input int i, output int cyc);
        cyc = 0;
        do begin
            @(negedge clock_in);
            cyc++;
        end while (ev[i] !== 1'b1 && cyc < 4000);
        if (cyc >= 4000) begin
            err_count++;
            $display("mismatch event %0d expected pulse seen none", i);
            stop_test();
        end
    endtask
    task automatic period(input int t, output int cyc);
        wait_ev(t, cyc);
        wait_ev(t, cyc);
    endtask
    // counter reset also loads the shadow range and divider
    task automatic set_tmr(input int t, input int a, input int b, input int res, input int src);
        @(negedge clock_in);
        tmr_cfg_in[t].divider_factor = 18'(a * 256 + b);
        tmr_cfg_in[t].counter_resolution = 5'(res);
        tmr_cfg_in[t].clock_source_select = src[0];
        tmr_cfg_in[t].counter_reset = 1'b1;
        @(negedge clock_in);
        tmr_cfg_in[t].counter_reset = 1'b0;
    endtask
    task automatic load_duty(input int c, input logic [24:0] d, input logic fade);
        @(negedge clock_in);
        chn_cfg_in[c].duty = d;
        chn_cfg_in[c].duty_load = 1'b1;
        chn_cfg_in[c].fade_start = fade;
        @(negedge clock_in);
        chn_cfg_in[c].duty_load = 1'b0;
        chn_cfg_in[c].fade_start = 1'b0;
    endtask
    task automatic reset_chk();
        chk_vec("pwm in reset", 25'h0, 25'(pwm_out));
        chk_vec("count in reset", 25'h0, 25'(tmr_count_out[0]));
        chk_vec("duty in reset", 25'h0, duty_now_out[0]);
    endtask
    // input clocks per source tick for one row
    function automatic int gap(input lpf_row_s r);
        if (r.src == 0) return REF_GAP;
        if (r.t < 4 || r.slow == 1) return 1;
        return K8_GAP;
    endfunction

    // =====================================================================
    // main sequence
    initial begin
        repeat (4) @(negedge clock_in);
        reset_chk();
        resetn_in = 1'b1;
        foreach (rows[i]) begin
            slow_clk_apb_sel_in = rows[i].slow[0];
            set_tmr(rows[i].t, rows[i].a, rows[i].b, rows[i].res, rows[i].src);
            period(rows[i].t, n);
            chk_int("period", gap(rows[i]) * ((rows[i].a * 256 + rows[i].b) << rows[i].res) / 256, n);
        end
        // high-speed range change waits for the next overflow
        slow_clk_apb_sel_in = 1'b1;
        set_tmr(1, 1, 0, 3, 1);
        wait_ev(1, n);
        tmr_cfg_in[1].counter_resolution = 5'h4;
        wait_ev(1, n);
        chk_int("hs old period", 1 << 3, n);
        wait_ev(1, n);
        chk_int("hs new period", 1 << 4, n);
        // low-speed change is held until the update bit
        set_tmr(5, 1, 0, 3, 1);
        wait_ev(5, n);
        tmr_cfg_in[5].counter_resolution = 5'h4;
        period(5, n);
        chk_int("ls held period", 1 << 3, n);
        tmr_cfg_in[5].low_speed_param_update = 1'b1;
        @(negedge clock_in);
        tmr_cfg_in[5].low_speed_param_update = 1'b0;
        wait_ev(5, n);
        period(5, n);
        chk_int("ls new period", 1 << 4, n);
        // the overflow pulse shows count 0; one more edge brings it to 1, then pause
        wait_ev(1, n);
        @(negedge clock_in);
        tmr_cfg_in[1].pause = 1'b1;
        repeat (6) @(negedge clock_in);
        chk_vec("paused count", 25'h1, 25'(tmr_count_out[1]));
        tmr_cfg_in[1].counter_reset = 1'b1;
        repeat (2) @(negedge clock_in);
        chk_vec("cleared count", 25'h0, 25'(tmr_count_out[1]));
        tmr_cfg_in[1].counter_reset = 1'b0;
        tmr_cfg_in[1].pause = 1'b0;
        // on-time over whole periods: ch0 dithered on timer 0, ch8 on timer 5
        set_tmr(0, 1, 0, 3, 1);
        chn_cfg_in[0].channel_high_point = 20'h00001;
        chn_cfg_in[8].channel_high_point = 20'h00002;
        chn_cfg_in[8].timer_select = 2'h1;
        load_duty(0, 25'h0000028, 1'b0);
        load_duty(8, 25'h0000030, 1'b0);
        repeat (32) @(negedge clock_in);
        clear = 1'b0;
        repeat (128) @(negedge clock_in);
        chk_vec("ch0 on time", 25'(16 * 2 + 16 * 8 / 16), 25'(on_cycles[0]));
        chk_vec("ch8 on time", 25'(128 / 16 * 3), 25'(on_cycles[8]));
        clear = 1'b1;
        // fades up on a high-speed channel and down on a low-speed one
        chn_cfg_in[0].fade_increment = 1'b1;
        chn_cfg_in[0].fade_scale = 10'h001;
        chn_cfg_in[0].fade_cycle = 10'h001;
        chn_cfg_in[0].fade_num = 10'h003;
        load_duty(0, 25'h0000020, 1'b1);
        wait_ev(8, n);
        chk_vec("ch0 fade up", 25'h0000020 + 25'(3 << 4), duty_now_out[0]);
        repeat (40) @(negedge clock_in);
        chk_vec("ch0 fade held", 25'h0000020 + 25'(3 << 4), duty_now_out[0]);
        chn_cfg_in[8].fade_increment = 1'b0;
        chn_cfg_in[8].fade_scale = 10'h001;
        chn_cfg_in[8].fade_cycle = 10'h002;
        chn_cfg_in[8].fade_num = 10'h002;
        load_duty(8, 25'h0000030, 1'b1);
        wait_ev(16, n);
        chk_vec("ch8 fade down", 25'h0000030 - 25'(2 << 4), duty_now_out[8]);
        // second reset in mid-run
        resetn_in = 1'b0;
        @(negedge clock_in);
        reset_chk();
        stop_test();
    end
endmodule // lpf_led_pwm_test
